// *** include/rdrc_pkg.sv ***
// Package: register address, field layout, reset values and widths
package rdrc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FRAC_W = 24;
    localparam logic [7:0] REG_ADDR = 8'h03;
    localparam int DRV_HI = 31;
    localparam int DRV_LO = 30;
    localparam int ACT_BIT = 28;
    localparam int SRC_BIT = 27;
    localparam int XKA_BIT = 26;
    localparam int DEN_HI = 19;
    localparam int DEN_LO = 16;
    localparam int HALF_HI = 11;
    localparam int HALF_LO = 8;
    localparam int EXP_HI = 7;
    localparam int EXP_LO = 4;
    localparam int MAN_HI = 3;
    localparam int MAN_LO = 0;
    // Writable bits only; unused positions always read zero
    localparam logic [31:0] WR_MASK = 32'hDC0F0FFF;
    localparam logic [31:0] RESET_VAL = 32'h10000000;
    localparam logic [3:0] MAN_ZERO = 4'h0;
    localparam logic [23:0] FRAC_ZERO = 24'h000000;

    typedef enum logic [1:0] {
        RDRC_CMOS   = 2'b00,
        RDRC_LVDS   = 2'b01,
        RDRC_LVPECL = 2'b10,
        RDRC_HCSL   = 2'b11
    } rdrc_drv_t;

    typedef enum logic [0:0] {
        RDRC_IDLE = 1'b0,
        RDRC_RAMP = 1'b1
    } rdrc_state_t;
endpackage : rdrc_pkg

// *** rtl/rdrc_ramp.sv ***
// Stepwise ramp of the fractional feedback divider toward a new target
module rdrc_ramp (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Step control
    input wire logic [3:0] mantissa,
    input wire logic [3:0] exponent,
    // Target and applied value
    input wire logic [rdrc_pkg::FRAC_W-1:0] target,
    output logic [rdrc_pkg::FRAC_W-1:0] frac_value,
    output logic ramping
);
    rdrc_pkg::rdrc_state_t state;
    logic [rdrc_pkg::FRAC_W-1:0] step;
    logic [rdrc_pkg::FRAC_W-1:0] diff;
    logic up;

    // Step is mantissa << exponent; mantissa 1, exponent 0 is finest
    assign step = rdrc_pkg::FRAC_W'({20'h00000, mantissa} << exponent);
    assign up = target > frac_value;
    assign diff = up ? target - frac_value : frac_value - target;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frac_value <= rdrc_pkg::FRAC_ZERO;
            state <= rdrc_pkg::RDRC_IDLE;
        end else if (ce) begin
            if (mantissa == rdrc_pkg::MAN_ZERO) begin
                frac_value <= target;
                state <= rdrc_pkg::RDRC_IDLE;
            end else if (diff <= step) begin
                // Last partial step lands exactly, never overshoots
                frac_value <= target;
                state <= rdrc_pkg::RDRC_IDLE;
            end else begin
                frac_value <= up ? frac_value + step
                                 : frac_value - step;
                state <= rdrc_pkg::RDRC_RAMP;
            end
        end
    end

    always_comb begin
        case (state)
            rdrc_pkg::RDRC_IDLE: ramping = 1'b0;
            rdrc_pkg::RDRC_RAMP: ramping = 1'b1;
            default: ramping = 1'b0;
        endcase
    end

    a_ramp_zero_man: assert property (@(posedge clk) disable iff (!arst_n)
        ce && mantissa == 4'h0 |=> frac_value == $past(target))
        else $error("zero mantissa did not apply target at once");
    a_ramp_step_size: assert property (@(posedge clk) disable iff (!arst_n)
        ce && mantissa != 4'h0 && diff > step
        |=> (frac_value == $past(frac_value) + $past(step))
         || (frac_value == $past(frac_value) - $past(step)))
        else $error("ramp moved by wrong step");
    c_ramp_active: cover property (@(posedge clk) disable iff (!arst_n)
        ramping ##1 !ramping);
endmodule : rdrc_ramp

// *** rtl/rdrc_ctrl.sv ***
// Reference-output, divider-enable and ramp control register
// What this block does
// - Two-bit field picks reference output standard
// - Source bit selects reference 2 over 1
// - Keep-alive holds crystal one always running
// - Four bits enable output dividers four..one
// - Half-step bit forces divide by 4.5
// - Ramp changes by mantissa shifted by exponent
// - Zero mantissa applies new value immediately
// - Fields take 0..15; mantissa 1, exponent 0 is slowest
// - Register decodes at host address 3
module rdrc_ctrl (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Host register port (already in clk domain)
    input wire logic [rdrc_pkg::ADDR_W-1:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [rdrc_pkg::DATA_W-1:0] host_wdata,
    output logic [rdrc_pkg::DATA_W-1:0] host_rdata,
    output logic host_hit,
    // Reference output control
    output logic [1:0] ref_out_driver_standard,
    output logic ref_out_comp_tristate,
    output logic ref_out_use_ref2,
    output logic activity_detect_on,
    output logic crystal_one_run,
    input wire logic ref1_selected,
    // Output dividers
    output logic [3:0] divider_enable,
    output logic [3:0] half_step_divide_on,
    // Fractional feedback divider
    input wire logic [rdrc_pkg::FRAC_W-1:0] frac_target,
    output logic [rdrc_pkg::FRAC_W-1:0] frac_value,
    output logic frac_ramping
);
    logic [rdrc_pkg::DATA_W-1:0] ctrl;
    logic [rdrc_pkg::DATA_W-1:0] next_ctrl;
    logic sel;
    logic ref1_meta;
    logic ref1_sync;

    function automatic logic addr_match(input logic [7:0] a);
        return a == rdrc_pkg::REG_ADDR;
    endfunction : addr_match

    assign sel = addr_match(host_addr);
    assign host_hit = sel && (host_wr || host_rd);
    // Unused bits are dropped on write so they always read zero
    assign next_ctrl = host_wdata & rdrc_pkg::WR_MASK;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= rdrc_pkg::RESET_VAL;
        end else if (ce && host_wr && sel) begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_rdata <= '0;
        end else if (ce && host_rd) begin
            host_rdata <= sel ? ctrl : '0;
        end
    end

    // Reference selection comes from elsewhere on the chip
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref1_meta <= 1'b0;
            ref1_sync <= 1'b0;
        end else if (ce) begin
            ref1_meta <= ref1_selected;
            ref1_sync <= ref1_meta;
        end
    end

    assign ref_out_driver_standard =
        ctrl[rdrc_pkg::DRV_HI:rdrc_pkg::DRV_LO];
    // Only CMOS mode leaves the complementary pin undriven
    assign ref_out_comp_tristate = ctrl[rdrc_pkg::DRV_HI:rdrc_pkg::DRV_LO]
        == rdrc_pkg::RDRC_CMOS;
    assign ref_out_use_ref2 = ctrl[rdrc_pkg::SRC_BIT];
    // Reset value is 1; a 0 written by software is passed on as is
    assign activity_detect_on = ctrl[rdrc_pkg::ACT_BIT];
    assign crystal_one_run = ctrl[rdrc_pkg::XKA_BIT] || ref1_sync;
    // Bit 19 drives output 4 down to bit 16 for output 1
    assign divider_enable = ctrl[rdrc_pkg::DEN_HI:rdrc_pkg::DEN_LO];
    // Bit 8 is output 1, bit 11 output 4; divider ignores integer value
    assign half_step_divide_on =
        ctrl[rdrc_pkg::HALF_HI:rdrc_pkg::HALF_LO];

    rdrc_ramp u_ramp (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .mantissa(ctrl[rdrc_pkg::MAN_HI:rdrc_pkg::MAN_LO]),
        .exponent(ctrl[rdrc_pkg::EXP_HI:rdrc_pkg::EXP_LO]),
        .target(frac_target),
        .frac_value(frac_value),
        .ramping(frac_ramping)
    );

    a_reg_write: assert property (@(posedge clk) disable iff (!arst_n)
        ce && host_wr && host_addr == 8'h03
        |=> ctrl == ($past(host_wdata) & 32'hDC0F0FFF))
        else $error("write to address 3 not stored");
    a_other_addr: assert property (@(posedge clk) disable iff (!arst_n)
        host_wr && host_addr != 8'h03 |=> $stable(ctrl))
        else $error("write elsewhere changed register");
    a_unused_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrl & 32'h23F0F000) == 32'h0)
        else $error("unused bit set");
    a_drv_mode: assert property (@(posedge clk) disable iff (!arst_n)
        ref_out_driver_standard == ctrl[31:30]
        && ref_out_comp_tristate == (ctrl[31:30] == 2'b00))
        else $error("driver mode mismatch");
    a_src_sel: assert property (@(posedge clk) disable iff (!arst_n)
        ref_out_use_ref2 == ctrl[27])
        else $error("source select mismatch");
    a_xtal_run: assert property (@(posedge clk) disable iff (!arst_n)
        ctrl[26] |-> crystal_one_run)
        else $error("crystal stopped while kept alive");
    a_div_order: assert property (@(posedge clk) disable iff (!arst_n)
        divider_enable[3] == ctrl[19] && divider_enable[0] == ctrl[16])
        else $error("divider enable order wrong");
    a_half_order: assert property (@(posedge clk) disable iff (!arst_n)
        half_step_divide_on[0] == ctrl[8]
        && half_step_divide_on[3] == ctrl[11])
        else $error("half-step order wrong");
    a_act_default: assert property (@(posedge clk)
        !arst_n |=> activity_detect_on)
        else $error("activity detect not on after reset");
    a_read_back: assert property (@(posedge clk) disable iff (!arst_n)
        ce && host_rd && host_addr == 8'h03 && !host_wr
        |=> host_rdata == ctrl)
        else $error("read data wrong");

    // Decode of the host port strobe qualifier
    a_hit_decode: assert property (@(posedge clk) disable iff (!arst_n)
        host_hit == (host_addr == 8'h03 && (host_wr || host_rd)))
        else $error("host hit decode wrong");

    // Any other address must read back as zero
    a_rd_elsewhere: assert property (@(posedge clk) disable iff (!arst_n)
        ce && host_rd && host_addr != 8'h03 |=> host_rdata == 32'h0)
        else $error("read of other address not zero");

    // A low enable freezes every piece of state in the block
    a_ce_freeze: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> $stable(ctrl) && $stable(host_rdata) && $stable(frac_value))
        else $error("state moved while enable low");

    // Read data stands until the next read strobe
    a_rdata_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !(ce && host_rd) |=> $stable(host_rdata))
        else $error("read data changed without a read");

    // Crystal one must run whenever reference 1 is in use
    a_xtal_ref1: assert property (@(posedge clk) disable iff (!arst_n)
        ref1_sync |-> crystal_one_run)
        else $error("crystal stopped while reference 1 selected");

    // Without keep-alive or reference 1 the oscillator may rest
    a_xtal_off: assert property (@(posedge clk) disable iff (!arst_n)
        !ctrl[26] && !ref1_sync |-> !crystal_one_run)
        else $error("crystal running with no reason");

    a_act_follow: assert property (@(posedge clk) disable iff (!arst_n)
        activity_detect_on == ctrl[28])
        else $error("activity detect does not follow register");

    a_div_middle: assert property (@(posedge clk) disable iff (!arst_n)
        divider_enable[2] == ctrl[18] && divider_enable[1] == ctrl[17])
        else $error("middle divider enables misplaced");

    a_half_middle: assert property (@(posedge clk) disable iff (!arst_n)
        half_step_divide_on[1] == ctrl[9]
        && half_step_divide_on[2] == ctrl[10])
        else $error("middle half-step bits misplaced");

    // Zero mantissa never leaves the ramp busy
    a_zero_no_ramp: assert property (@(posedge clk) disable iff (!arst_n)
        ce && ctrl[3:0] == 4'h0 |=> !frac_ramping)
        else $error("ramp busy with zero mantissa");

    // Power-on defaults: CMOS drive, dividers off, ramp at rest
    a_drv_reset: assert property (@(posedge clk)
        !arst_n |=> ref_out_driver_standard == 2'b00)
        else $error("driver mode not CMOS after reset");

    a_div_reset: assert property (@(posedge clk)
        !arst_n |=> divider_enable == 4'h0
        && half_step_divide_on == 4'h0)
        else $error("dividers not cleared by reset");

    a_src_reset: assert property (@(posedge clk)
        !arst_n |=> !ref_out_use_ref2)
        else $error("reference 2 selected after reset");

    a_frac_reset: assert property (@(posedge clk)
        !arst_n |=> frac_value == 24'h000000 && !frac_ramping)
        else $error("ramp not at rest after reset");

    c_write_reg: cover property (@(posedge clk) disable iff (!arst_n)
        ce && host_wr && sel);
    c_hcsl: cover property (@(posedge clk) disable iff (!arst_n)
        ref_out_driver_standard == 2'b11);
    c_half_step: cover property (@(posedge clk) disable iff (!arst_n)
        half_step_divide_on != 4'h0);
    // Ramp busy and crystal held up by the reference selection alone
    c_ramp_busy: cover property (@(posedge clk) disable iff (!arst_n)
        frac_ramping);
    c_xtal_ref1: cover property (@(posedge clk) disable iff (!arst_n)
        ref1_sync && !ctrl[26]);
endmodule : rdrc_ctrl

// *** dv/rdrc_ctrl_test.sv ***
// Self-checking testbench for the reference-output and ramp control register
module rdrc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, arst_n = 0, ce = 1, host_wr = 0, host_rd = 0;
    logic ref1_selected = 0, host_hit, ref_out_comp_tristate;
    logic ref_out_use_ref2, activity_detect_on, crystal_one_run, frac_ramping;
    logic [7:0] host_addr = 8'h00;
    logic [31:0] host_wdata = 32'h00000000, host_rdata, d;
    logic [1:0] ref_out_driver_standard;
    logic [3:0] divider_enable, half_step_divide_on;
    logic [23:0] frac_target = 24'h000000, frac_value, fexp, step;
    logic [31:0] exp_q[$];
    logic [35:0] ramps[5] = '{36'h103000003, 36'h320000064, 36'h050ABCDE,
        36'hFF000000, 36'h14000100};
    bit rd_seen = 0;
    int err_total = 0, checks_done = 0, seed = 14;

    always #50 clk = ~clk;

    rdrc_ctrl dut_u (.clk(clk), .arst_n(arst_n), .ce(ce),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_hit(host_hit),
        .ref_out_driver_standard(ref_out_driver_standard),
        .ref_out_comp_tristate(ref_out_comp_tristate),
        .ref_out_use_ref2(ref_out_use_ref2),
        .activity_detect_on(activity_detect_on),
        .crystal_one_run(crystal_one_run), .ref1_selected(ref1_selected),
        .divider_enable(divider_enable),
        .half_step_divide_on(half_step_divide_on),
        .frac_target(frac_target), .frac_value(frac_value),
        .frac_ramping(frac_ramping));

    task automatic check(input logic [31:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Strobes are one cycle wide, raised and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge clk);
        host_addr = a;
        host_wdata = v;
        host_wr = 1;
        @(negedge clk);
        host_wr = 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        host_addr = a;
        host_rd = 1;
        exp_q.push_back(e);
        #1;
        check(host_hit, a == rdrc_pkg::REG_ADDR, "host hit");
        @(negedge clk);
        host_rd = 0;
    endtask : rd

    // Read data is registered: look one falling edge after the taking edge
    always @(posedge clk) rd_seen <= host_rd & ce & arst_n;
    always @(negedge clk) begin
        if (rd_seen) begin
            check(host_rdata, exp_q.pop_front(), "read data");
        end
    end

    initial begin
        #1000000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        fexp = 24'h000000;
        repeat (3) @(negedge clk);
        arst_n = 1;
        rd(8'h03, rdrc_pkg::RESET_VAL);
        check(ref_out_comp_tristate, 1, "tristate at reset");
        check(activity_detect_on, 1, "activity detect at reset");
        for (int m = 0; m < 4; m++) begin
            wr(8'h03, {m[1:0], 30'h10000000});
            check(ref_out_driver_standard, m, "driver mode");
            check(ref_out_comp_tristate, m == 0, "tristate");
        end
        repeat (6) begin
            // Software keeps unused bits zero and activity detect on
            d = $random(seed) & rdrc_pkg::WR_MASK | 32'h10000000;
            wr(8'h03, d);
            rd(8'h03, d & rdrc_pkg::WR_MASK);
            check(ref_out_use_ref2, d[27], "ref2 select");
            check(activity_detect_on, 1, "activity detect");
            check(crystal_one_run, d[26], "keep alive");
            check(divider_enable, d[19:16], "divider enables");
            check(half_step_divide_on, d[11:8], "half step");
        end
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h00000000);
        ce = 0;
        wr(8'h03, 32'h00000000);
        ce = 1;
        rd(8'h03, d & rdrc_pkg::WR_MASK);
        wr(8'h03, 32'h10000000);
        ref1_selected = 1;
        repeat (4) @(negedge clk);
        check(crystal_one_run, 1, "osc on for ref1");
        ref1_selected = 0;
        repeat (4) @(negedge clk);
        check(crystal_one_run, 0, "osc idle");
        // Each entry: mantissa, exponent, target; step walks in the bench
        foreach (ramps[i]) begin
            wr(8'h03, {24'h100000, ramps[i][31:28], ramps[i][35:32]});
            frac_target = ramps[i][23:0];
            step = {20'h00000, ramps[i][35:32]} << ramps[i][31:28];
            repeat (20) begin
                @(negedge clk);
                if (step == 0 || (fexp > frac_target ? fexp - frac_target
                        : frac_target - fexp) <= step) begin
                    fexp = frac_target;
                end else if (fexp > frac_target) begin
                    fexp = fexp - step;
                end else begin
                    fexp = fexp + step;
                end
                check(frac_value, fexp, "ramp value");
                check(frac_ramping, fexp != frac_target, "ramping");
            end
        end
        tally_and_finish();
    end
endmodule : rdrc_ctrl_test
